// File: rtl/fuse_trim_pulse_programmer.sv
// Pulse-driven trim programming state machine with fuse control
`timescale 1ns/100ps

// Overview of operation
// [R1] Pin classed low, mid or high by thresholds
// [R2] Programmer holds state-change highs at least 20us
// [R3] Programmer holds fuse-blow highs at least 100us
// [R4] Programmer holds step lows at least 6us
// [R5] Programmer dwells mid 15us after high
// [R6] Programmer holds mid intervals at least 6us
// [R7] Mid to low fall counts one step
// [R8] Reset: Initial state, intact bits zero
// [R9] Initial state ignores low pulses
// [R10] High pulse in Initial enters Mode Selection
// [R11] Step count 1,2,3 picks try, blow, lock
// [R12] Mode counter wraps back to start
// [R13] High before any step changes nothing
// [R14] High after steps latches mode, selects register
// [R15] Step count selects register, wraps after seventh
// [R16] Register widths 2,9,2,8,5,2,1 bits
// [R17] High in Register Selection enters Bitfield Selection
// [R18] Try mode step increments value, applied immediately
// [R19] Programmer blows one bitfield per sequence
// [R20] Try mode high keeps value, back to mode
// [R21] Blow mode high blows fuse, back to mode
// [R22] Blown lock fuse disables all programming
// [R23] High rise changes state; fall steps selection
// [R24] Entering bitfield clears intact bits of register
// [R25] Programmer power-cycles before each blow sequence
// [R26] Levels count only after minimum duration
// [R27] Locked device stays Initial, ignores pulses
module fuse_trim_pulse_programmer
	import fuse_trim_pkg::*;
(
	// Clock and power-up reset
	input  wire logic              clk,
	input  wire logic              rst,
	// Comparator outputs watching the output pin
	input  wire logic              above_low_thr,
	input  wire logic              above_mid_thr,
	input  wire logic              above_high_thr,
	// Sensed fuse states, one when blown
	input  wire logic [FUSE_W-1:0] fuse_sense,
	// Fuse blow control
	output logic                   fuse_blow_en,
	output logic [FUSE_W-1:0]      fuse_blow_mask,
	// Trim values to the analog path
	output trim_s                  trim,
	// Status
	output prog_state_e            prog_state,
	output logic                   device_locked
);

	// Extract one trim register from the packed vector
	function automatic logic [FIELD_W-1:0] field_get(input logic [TRIM_W-1:0] vec, input logic [2:0] idx);
		logic [FIELD_W-1:0] v;
		v = '0;
		for (int i = 0; i < FIELD_W; i++) begin
			if (i < REG_WIDTH[idx])
				v[i] = vec[REG_OFFSET[idx] + i];
		end
		return v;
	endfunction

	// Replace one trim register in the packed vector
	function automatic logic [TRIM_W-1:0] field_put(input logic [TRIM_W-1:0] vec, input logic [2:0] idx,
		input logic [FIELD_W-1:0] val);
		logic [TRIM_W-1:0] r;
		r = vec;
		for (int i = 0; i < FIELD_W; i++) begin
			if (i < REG_WIDTH[idx])
				r[REG_OFFSET[idx] + i] = val[i];
		end
		return r;
	endfunction

	// Next code of a register, wrapping past its last legal code
	function automatic logic [FIELD_W-1:0] field_inc(input logic [FIELD_W-1:0] cur, input logic [2:0] idx);
		logic [FIELD_W-1:0] lim;
		lim = FIELD_W'(REG_MAX[idx]);
		return (cur >= lim) ? '0 : cur + 1'b1;
	endfunction

	// Spread a bitfield value onto the fuse positions of a register
	function automatic logic [FUSE_W-1:0] fuse_spread(input logic [2:0] idx, input logic [FIELD_W-1:0] val);
		logic [FUSE_W-1:0] m;
		m = '0;
		m[TRIM_W-1:0] = field_put('0, idx, val);
		return m;
	endfunction

	pin_event_s          ev;
	prog_state_e         state_reg, state_next;
	logic [1:0]          mode_cnt_reg, mode_cnt_next;
	logic [1:0]          mode_reg, mode_next;
	logic [2:0]          reg_sel_reg, reg_sel_next;
	logic [FIELD_W-1:0]  field_val_reg, field_val_next;
	logic [TRIM_W-1:0]   trim_vol_reg, trim_vol_next;
	logic [TRIM_W-1:0]   trim_out_reg, trim_out_next;
	logic                blow_en_reg, blow_en_next;
	logic [FUSE_W-1:0]   blow_mask_reg, blow_mask_next;
	logic                locked;
	logic [TRIM_W-1:0]   trim_eff;
	logic [FIELD_W-1:0]  cur_val;

	// Pin level qualification
	pulse_level_qualifier u_qual (
		.clk            (clk),
		.rst            (rst),
		.above_low_thr  (above_low_thr),
		.above_mid_thr  (above_mid_thr),
		.above_high_thr (above_high_thr),
		.ev             (ev)
	);

	// Blown fuses force their bit to one; the lock fuse gates programming
	assign locked   = fuse_sense[LOCK_FUSE_BIT];
	assign trim_eff = trim_vol_reg | fuse_sense[TRIM_W-1:0]; // see [R24]
	assign cur_val  = field_get(trim_eff, reg_sel_reg);

	// Programming state machine next values
	always_comb begin
		state_next     = state_reg;
		mode_cnt_next  = mode_cnt_reg;
		mode_next      = mode_reg;
		reg_sel_next   = reg_sel_reg;
		field_val_next = field_val_reg;
		trim_vol_next  = trim_vol_reg;
		blow_en_next   = 1'b0;
		blow_mask_next = blow_mask_reg;
		case (state_reg)
			ST_INITIAL: begin
				// Steps are ignored here
				if (ev.high_start && !locked) begin // see [R9] [R27]
					state_next    = ST_MODE_SEL; // see [R10]
					mode_cnt_next = MODE_NONE;
				end
			end
			ST_MODE_SEL: begin
				if (ev.step)
					mode_cnt_next = mode_cnt_reg + 1'b1; // see [R11] [R12]
				if (ev.high_start && mode_cnt_reg != MODE_NONE) begin // see [R13]
					state_next   = ST_REG_SEL; // see [R14]
					mode_next    = mode_cnt_reg;
					reg_sel_next = '0;
				end
			end
			ST_REG_SEL: begin
				if (ev.step)
					reg_sel_next = (reg_sel_reg == LAST_REG) ? 3'h0 : reg_sel_reg + 1'b1; // see [R15]
				if (ev.high_start) begin
					state_next     = ST_FIELD_SEL; // see [R17]
					field_val_next = '0;
					// Intact bits of the chosen register start from zero
					trim_vol_next  = field_put(trim_vol_reg, reg_sel_reg, '0); // see [R24]
				end
			end
			ST_FIELD_SEL: begin
				if (ev.step) begin
					if (mode_reg == MODE_TRY) begin
						// Value applied at once so the output can be measured
						trim_vol_next = field_put(trim_vol_reg, reg_sel_reg,
							field_inc(cur_val, reg_sel_reg)); // see [R18] [R16]
					end else begin
						field_val_next = field_inc(field_val_reg, reg_sel_reg);
					end
				end
				if (ev.high_start) begin
					if (mode_reg == MODE_TRY) begin
						state_next    = ST_MODE_SEL; // see [R20]
						mode_cnt_next = MODE_NONE;
					end else begin
						state_next   = ST_BLOW;
						blow_en_next = 1'b1;
						if (mode_reg == MODE_LOCK) begin
							// Only the lock address reaches the lock fuse
							blow_mask_next = '0;
							if (reg_sel_reg == LOCK_REG_SEL && field_val_reg == LOCK_FIELD_VAL)
								blow_mask_next[LOCK_FUSE_BIT] = 1'b1; // see [R22]
						end else begin
							blow_mask_next = fuse_spread(reg_sel_reg, field_val_reg); // see [R21]
						end
					end
				end
			end
			ST_BLOW: begin
				// Fuse current flows for as long as the high level lasts
				if (ev.high_present) begin
					blow_en_next = 1'b1; // see [R21]
				end else begin
					state_next     = ST_MODE_SEL;
					mode_cnt_next  = MODE_NONE;
					blow_mask_next = '0;
				end
			end
			default: begin
				state_next = ST_INITIAL;
			end
		endcase
		// A blown lock fuse ends programming once any blow is over
		if (locked && state_next != ST_BLOW)
			state_next = ST_INITIAL; // see [R22] [R27]
		trim_out_next = trim_vol_next | fuse_sense[TRIM_W-1:0];
	end

	// State registers; reset stands for power-up
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg     <= ST_INITIAL; // see [R8]
			mode_cnt_reg  <= MODE_NONE;
			mode_reg      <= MODE_NONE;
			reg_sel_reg   <= '0;
			field_val_reg <= '0;
			trim_vol_reg  <= '0; // see [R8]
			trim_out_reg  <= '0;
			blow_en_reg   <= 1'b0;
			blow_mask_reg <= '0;
		end else begin
			state_reg     <= state_next;
			mode_cnt_reg  <= mode_cnt_next;
			mode_reg      <= mode_next;
			reg_sel_reg   <= reg_sel_next;
			field_val_reg <= field_val_next;
			trim_vol_reg  <= trim_vol_next;
			trim_out_reg  <= trim_out_next;
			blow_en_reg   <= blow_en_next;
			blow_mask_reg <= blow_mask_next;
		end
	end

	// Outputs
	assign trim           = trim_s'(trim_out_reg);
	assign fuse_blow_en   = blow_en_reg;
	assign fuse_blow_mask = blow_en_reg ? blow_mask_reg : '0;
	assign prog_state     = state_reg;
	assign device_locked  = locked;

endmodule

// File: rtl/fuse_trim_pkg.sv
// Shared constants, types and helpers for the trim programming logic
package fuse_trim_pkg;

	// Core clock
	localparam longint CLK_HZ = 25_000_000;

	// Pulse timing minimums in microseconds
	localparam int STATE_CHANGE_PULSE_MIN_US = 20;
	localparam int FUSE_BLOW_PULSE_MIN_US    = 100;
	localparam int STEP_LOW_PULSE_MIN_US     = 6;
	localparam int POST_HIGH_DWELL_MIN_US    = 15;
	localparam int STEP_MID_INTERVAL_MIN_US  = 6;

	// Least time in us to clock cycles, rounded up, at least one
	function automatic int us_to_cyc(input int us);
		longint c;
		c = (longint'(us) * CLK_HZ + 64'd999_999) / 64'd1_000_000;
		return (c < 1) ? 1 : int'(c);
	endfunction

	// Cycle counts derived from the times above
	localparam int RUN_W              = 12;
	localparam int STATE_CHANGE_CYC   = us_to_cyc(STATE_CHANGE_PULSE_MIN_US);
	localparam int FUSE_BLOW_CYC      = us_to_cyc(FUSE_BLOW_PULSE_MIN_US);
	localparam int STEP_LOW_CYC       = us_to_cyc(STEP_LOW_PULSE_MIN_US);
	localparam int POST_HIGH_CYC      = us_to_cyc(POST_HIGH_DWELL_MIN_US);
	localparam int STEP_MID_CYC       = us_to_cyc(STEP_MID_INTERVAL_MIN_US);

	// Trim register set: order, widths, packing and code limits
	localparam int         NUM_REGS = 7;
	localparam logic [2:0] LAST_REG = 3'h6;
	localparam int         TRIM_W   = 29;
	localparam int         FIELD_W  = 9;
	localparam int         REG_WIDTH  [NUM_REGS] = '{2, 9, 2, 8, 5, 2, 1};
	localparam int         REG_OFFSET [NUM_REGS] = '{0, 2, 11, 13, 21, 26, 28};
	localparam int         REG_MAX    [NUM_REGS] = '{2, 511, 2, 255, 31, 2, 1};

	// Fuse array: one fuse per trim bit plus the device lock fuse
	localparam int FUSE_W        = 30;
	localparam int LOCK_FUSE_BIT = 29;

	// Lock fuse address inside Lock Device mode
	localparam logic [2:0]         LOCK_REG_SEL   = 3'h0;
	localparam logic [FIELD_W-1:0] LOCK_FIELD_VAL = 9'h001;

	// Mode codes picked by low pulse count
	localparam logic [1:0] MODE_NONE = 2'h0;
	localparam logic [1:0] MODE_TRY  = 2'h1;
	localparam logic [1:0] MODE_BLOW = 2'h2;
	localparam logic [1:0] MODE_LOCK = 2'h3;

	// Pin level classes
	typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH, LVL_EDGE} level_e;

	// Programming states
	typedef enum logic [2:0] {ST_INITIAL, ST_MODE_SEL, ST_REG_SEL, ST_FIELD_SEL, ST_BLOW} prog_state_e;

	// Qualified pin events
	typedef struct packed {
		logic step;
		logic high_start;
		logic high_present;
		logic high_long;
	} pin_event_s;

	// Trim values as seen by the analog path
	typedef struct packed {
		logic       output_sign_select;
		logic [1:0] output_limit_select;
		logic [4:0] gain_temperature_coefficient;
		logic [7:0] gain_fine;
		logic [1:0] gain_coarse;
		logic [8:0] quiescent_level_fine;
		logic [1:0] quiescent_level_coarse;
	} trim_s;

endpackage

// File: rtl/pulse_level_qualifier.sv
// Pin level classifier and pulse width qualifier
`timescale 1ns/100ps
module pulse_level_qualifier
	import fuse_trim_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Comparator outputs watching the output pin
	input  wire logic       above_low_thr,
	input  wire logic       above_mid_thr,
	input  wire logic       above_high_thr,
	// Qualified events
	output pin_event_s      ev
);

	logic [2:0]     sync1_reg;
	logic [2:0]     sync2_reg;
	level_e         cls;
	level_e         cls_reg;
	logic [RUN_W-1:0] run_reg, run_next;
	logic           armed_reg, armed_next;
	logic           after_high_reg, after_high_next;
	pin_event_s     ev_reg, ev_next;
	logic [RUN_W-1:0] mid_need;

	// Two-stage synchroniser for the comparator levels
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
		end else begin
			sync1_reg <= {above_high_thr, above_mid_thr, above_low_thr};
			sync2_reg <= sync1_reg;
		end
	end

	// Level class; between bands counts as an edge in flight
	always_comb begin
		if (sync2_reg[2])
			cls = LVL_HIGH;
		else if (sync2_reg[1])
			cls = LVL_MID;
		else if (!sync2_reg[0])
			cls = LVL_LOW;
		else
			cls = LVL_EDGE; // see [R1]
	end

	// Mid dwell needed: longer right after a high pulse
	assign mid_need = after_high_reg ? RUN_W'(POST_HIGH_CYC - 1) : RUN_W'(STEP_MID_CYC - 1); // see [R5] [R6]

	// Run length, arming and event generation
	always_comb begin
		run_next        = (cls != cls_reg) ? '0 : ((run_reg == {RUN_W{1'b1}}) ? run_reg : run_reg + 1'b1);
		armed_next      = armed_reg;
		after_high_next = after_high_reg;
		ev_next         = '0;
		case (cls_reg)
			LVL_HIGH: begin
				// Only a high held long enough counts
				if (run_reg == RUN_W'(STATE_CHANGE_CYC - 1)) begin
					ev_next.high_start = 1'b1; // see [R26] [R23]
					after_high_next    = 1'b1;
					armed_next         = 1'b0;
				end
				ev_next.high_present = (cls == LVL_HIGH) && (run_reg >= RUN_W'(STATE_CHANGE_CYC - 1));
				ev_next.high_long    = (cls == LVL_HIGH) && (run_reg >= RUN_W'(FUSE_BLOW_CYC - 1));
			end
			LVL_MID: begin
				if (run_reg == mid_need) begin
					armed_next      = 1'b1;
					after_high_next = 1'b0;
				end
			end
			LVL_LOW: begin
				// Mid to low fall, held long enough, is one step
				if (run_reg == RUN_W'(STEP_LOW_CYC - 1) && armed_reg) begin
					ev_next.step = 1'b1; // see [R7] [R26]
					armed_next   = 1'b0;
				end
			end
			default: begin
			end
		endcase
	end

	// State registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cls_reg        <= LVL_EDGE;
			run_reg        <= '0;
			armed_reg      <= 1'b0;
			after_high_reg <= 1'b0;
			ev_reg         <= '0;
		end else begin
			cls_reg        <= cls;
			run_reg        <= run_next;
			armed_reg      <= armed_next;
			after_high_reg <= after_high_next;
			ev_reg         <= ev_next;
		end
	end

	assign ev = ev_reg;

endmodule

// File: dv/trim_rules_chk.sv
// Port-level checks on the trim programmer
`timescale 1ns/100ps
module trim_rules_chk
	import fuse_trim_pkg::*;
(
	// Clock and reset
	input wire logic              clk,
	input wire logic              rst,
	// Pin and fuse inputs
	input wire logic              above_low_thr,
	input wire logic              above_mid_thr,
	input wire logic              above_high_thr,
	input wire logic [FUSE_W-1:0] fuse_sense,
	// Design outputs
	input wire logic              fuse_blow_en,
	input wire logic [FUSE_W-1:0] fuse_blow_mask,
	input wire trim_s             trim,
	input wire prog_state_e       prog_state,
	input wire logic              device_locked
);
	logic [11:0] hi_run_reg;
	logic [11:0] hi_run_next;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Cycles the pin has stayed high
	always_comb begin
		hi_run_next = above_high_thr ? hi_run_reg + 12'(hi_run_reg != 12'hFFF) : 12'h000;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hi_run_reg <= 12'h000;
		end else begin
			hi_run_reg <= hi_run_next;
		end
	end
	// Two idle cycles with fuses steady
	sequence init_twice;
		prog_state == ST_INITIAL ##1 prog_state == ST_INITIAL && $stable(fuse_sense);
	endsequence
	// Locked with no blow running
	sequence lock_quiet;
		(fuse_sense[LOCK_FUSE_BIT] && !fuse_blow_en) [*8];
	endsequence
	mask_gated_a: assert property (!fuse_blow_en |-> fuse_blow_mask == '0)
		else $error("blow mask while idle");
	lock_follow_a: assert property (device_locked == fuse_sense[LOCK_FUSE_BIT])
		else $error("lock flag wrong");
	locked_idle_a: assert property (lock_quiet |-> prog_state == ST_INITIAL)
		else $error("locked device left initial");
	// Trim shows fuses of the cycle before; skip the first clock after power-up
	blown_kept_a: assert property ($stable(fuse_sense) && !$past(rst)
		|-> (trim | fuse_sense[TRIM_W-1:0]) == trim) else $error("blown bit lost");
	blow_state_a: assert property ($rose(fuse_blow_en) |-> ##[0:2] prog_state == ST_BLOW)
		else $error("blow outside blow state");
	high_qualify_a: assert property ($changed(prog_state) && prog_state != ST_INITIAL
		&& $past(prog_state) != ST_BLOW |-> hi_run_reg >= 12'd500) else $error("state moved without high");
	init_hold_a: assert property (init_twice |=> $stable(trim))
		else $error("trim moved in initial");
	lock_noblow_a: assert property (fuse_sense[LOCK_FUSE_BIT] && !fuse_blow_en |=> !fuse_blow_en)
		else $error("blow after lock");
endmodule

bind fuse_trim_pulse_programmer trim_rules_chk u_chk (.clk(clk), .rst(rst), .above_low_thr(above_low_thr),
	.above_mid_thr(above_mid_thr), .above_high_thr(above_high_thr), .fuse_sense(fuse_sense),
	.fuse_blow_en(fuse_blow_en), .fuse_blow_mask(fuse_blow_mask), .trim(trim), .prog_state(prog_state),
	.device_locked(device_locked));

// File: dv/pin_src.sv
// Pulse programmer model driving the pin comparators
`timescale 1ns/100ps
module pin_src (
	// Clock
	input  wire logic clk,
	// Comparator levels
	output logic      above_low_thr,
	output logic      above_mid_thr,
	output logic      above_high_thr
);
	// Hold level 0 low, 1 mid, 2 high for n cycles
	task automatic put(input int lvl, input int n);
		@(posedge clk);
		#1;
		above_low_thr = lvl > 0;
		above_mid_thr = lvl > 0;
		above_high_thr = lvl > 1;
		repeat (n - 1) @(posedge clk);
	endtask
	// State change high, then mid dwell
	task automatic high();
		put(2, 520);
		put(1, 400);
	endtask
	// One low step and its mid gap
	task automatic step();
		put(0, 160);
		put(1, 160);
	endtask
	// Rest at mid
	initial begin
		above_low_thr = 1'b1;
		above_mid_thr = 1'b1;
		above_high_thr = 1'b0;
	end
endmodule

// File: dv/fuse_trim_pulse_programmer_bench.sv
// Self-checking bench for the trim programmer
`timescale 1ns/100ps
module fuse_trim_pulse_programmer_bench
	import fuse_trim_pkg::*;
;
	logic              clk;
	logic              rst;
	logic              above_low_thr;
	logic              above_mid_thr;
	logic              above_high_thr;
	logic [FUSE_W-1:0] fuse_sense;
	logic              fuse_blow_en;
	logic [FUSE_W-1:0] fuse_blow_mask;
	trim_s             trim;
	trim_s             exp_trim;
	prog_state_e       prog_state;
	logic              device_locked;
	logic [31:0]       notes[$];
	int                n_mismatch;
	int                cmp_count;
	int                n;
	pin_src u_pin_src (.clk(clk), .above_low_thr(above_low_thr), .above_mid_thr(above_mid_thr),
		.above_high_thr(above_high_thr));
	fuse_trim_pulse_programmer u_fuse_trim_pulse_programmer (.clk(clk), .rst(rst),
		.above_low_thr(above_low_thr), .above_mid_thr(above_mid_thr), .above_high_thr(above_high_thr),
		.fuse_sense(fuse_sense), .fuse_blow_en(fuse_blow_en), .fuse_blow_mask(fuse_blow_mask),
		.trim(trim), .prog_state(prog_state), .device_locked(device_locked));
	// 25 MHz clock
	initial clk = 1'b0;
	always #20 clk = ~clk;
	// Fuses open while blow current flows
	always @(posedge clk) begin
		if (fuse_blow_en === 1'b1) begin
			fuse_sense <= #1 fuse_sense | fuse_blow_mask;
		end
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, want, seen);
		end
	endtask
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic note(input prog_state_e st, input trim_s tr);
		notes.push_back({st, tr});
	endtask
	task automatic steps(input int k);
		repeat (k) u_pin_src.step();
	endtask
	task automatic hi();
		u_pin_src.high();
	endtask
	task automatic power_cycle();
		@(posedge clk);
		#1 rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		// Fuse state reaches the trim outputs one clock after power-up
		@(posedge clk);
	endtask
	// Oldest note against settled outputs
	always @(negedge clk) begin
		if (notes.size() > 0) begin
			check("state_trim", {prog_state, trim}, notes.pop_front());
		end
	end
	// Watchdog
	initial begin
		repeat (100000) @(posedge clk);
		n_mismatch++;
		conclude();
	end
	// Main sequence
	initial begin
		rst = 1'b1;
		fuse_sense = '0;
		n_mismatch = 0;
		cmp_count = 0;
		exp_trim = '0;
		void'($urandom(96723));
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		note(ST_INITIAL, exp_trim);
		steps(2);
		note(ST_INITIAL, exp_trim);
		u_pin_src.put(2, 100);
		u_pin_src.put(1, 400);
		note(ST_INITIAL, exp_trim);
		hi();
		note(ST_MODE_SEL, exp_trim);
		hi();
		note(ST_MODE_SEL, exp_trim);
		steps(5);
		hi();
		note(ST_REG_SEL, exp_trim);
		steps(8);
		hi();
		note(ST_FIELD_SEL, exp_trim);
		n = 1 + $urandom % 5;
		steps(n);
		exp_trim.quiescent_level_fine = 9'(n);
		note(ST_FIELD_SEL, exp_trim);
		hi();
		steps(1);
		hi();
		hi();
		steps(4);
		exp_trim.quiescent_level_coarse = 2'h1;
		note(ST_FIELD_SEL, exp_trim);
		hi();
		note(ST_MODE_SEL, exp_trim);
		power_cycle();
		exp_trim = '0;
		note(ST_INITIAL, exp_trim);
		hi();
		steps(2);
		hi();
		steps(4);
		hi();
		steps(4);
		u_pin_src.put(2, 2600);
		@(negedge clk);
		check("blow_en", 32'(fuse_blow_en), 32'h1);
		check("blow_mask", 32'(fuse_blow_mask), 32'h0080_0000);
		u_pin_src.put(1, 400);
		exp_trim.gain_temperature_coefficient = 5'h04;
		note(ST_MODE_SEL, exp_trim);
		power_cycle();
		note(ST_INITIAL, exp_trim);
		hi();
		steps(3);
		hi();
		hi();
		steps(1);
		u_pin_src.put(2, 2600);
		@(negedge clk);
		check("lock_mask", 32'(fuse_blow_mask), 32'h2000_0000);
		u_pin_src.put(1, 400);
		@(negedge clk);
		check("locked", 32'(device_locked), 32'h1);
		hi();
		steps(1);
		note(ST_INITIAL, exp_trim);
		// Let the watcher take the last note before the verdict
		repeat (2) @(negedge clk);
		conclude();
	end
endmodule
